// ### sawd_adc_control.sv
`timescale 1ns/1ps
// Summary of operation
// - sar clock is system clock over divider+1; a divider of zero holds it high
// - every result compared, window flag set on a hit
// - limit ordering picks inside or outside
// - single-ended results and compare unsigned
// - lt above gt: strictly between sets flag
// - gt above lt: outside sets flag
// - right-justified differential results sign-extended two's complement
// - differential compare is signed
// - conversion lasts ten sar clocks
// - busy falls at end, sets done flag
// - timer 2/3 overflow byte follows width
// - external start: track low, convert rising
// - ground negative input means single-ended
module sawd_adc_control
#(
   parameter int DATA_BITS = 10
)
(
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic      [31:0]          prdata,
   output logic                      pslverr,
   input  wire sawd_pkg::sawd_timers_t timers,
   input  wire logic                 externalStartInput,
   input  wire logic [DATA_BITS-1:0] sarCode,
   output logic                      sarClock,
   output logic                      trackEnable,
   output logic                      convertActive,
   output logic                      irq
);

   ////////////////////////////////////////////////////////////////////////////
   logic rstMeta;
   logic rstSync;

   // reset released through two flops
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]  config_r;
   logic [7:0]  control;
   logic [7:0]  modeReg;
   logic [7:0]  gtLow;
   logic [7:0]  gtHigh;
   logic [7:0]  ltLow;
   logic [7:0]  ltHigh;
   logic [15:0] result;
   logic [1:0]  irqStat;
   logic [1:0]  irqMask;
   logic [4:0]  divCount;
   logic        sarTick;
   logic [3:0]  phaseCount;
   logic        extPrev;
   sawd_pkg::sawd_state_t state;

   logic [7:0]  next_config;
   logic [7:0]  next_control;
   logic [7:0]  next_modeReg;
   logic [7:0]  next_gtLow;
   logic [7:0]  next_gtHigh;
   logic [7:0]  next_ltLow;
   logic [7:0]  next_ltHigh;
   logic [15:0] next_result;
   logic [1:0]  next_irqStat;
   logic [1:0]  next_irqMask;
   logic [4:0]  next_divCount;
   logic        next_sarTick;
   logic [3:0]  next_phaseCount;
   sawd_pkg::sawd_state_t next_state;
   logic        next_pready;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        next_irq;
   logic        next_sarClock;

   logic        setup;
   logic        addrOk;
   logic        wrEn;
   logic [7:0]  wIdx;
   logic [7:0]  wByte;
   logic        startEvent;
   logic        extRise;
   logic        singleEnded;
   logic        finish;
   logic [15:0] word;
   logic        winHit;

   // window compare on justified words; signed when differential
   function automatic logic greaterThan(input logic [15:0] a, input logic [15:0] b, input logic sgn);
      if (sgn)
         greaterThan = $signed(a) > $signed(b);
      else
         greaterThan = a > b;
   endfunction

   assign setup = psel && !penable;
   assign addrOk = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
   assign wrEn  = psel && penable && pwrite && pready && addrOk;
   assign wIdx  = paddr[9:2];
   assign wByte = pwdata[7:0];
   assign singleEnded = modeReg[sawd_pkg::BIT_NEG_GND];
   assign extRise = externalStartInput && !extPrev;

   // start source decode
   always_comb
   begin
      startEvent = 1'b0;
      case (control[2:0])
         sawd_pkg::SRC_SOFTWARE: startEvent = wrEn && wIdx == sawd_pkg::IDX_CONTROL && wByte[sawd_pkg::BIT_BUSY];
         sawd_pkg::SRC_TIMER0:   startEvent = timers.timer0;
         sawd_pkg::SRC_TIMER2:   startEvent = timers.timer2Wide ? timers.timer2High : timers.timer2Low;
         sawd_pkg::SRC_TIMER1:   startEvent = timers.timer1;
         sawd_pkg::SRC_EXTERNAL: startEvent = extRise;
         sawd_pkg::SRC_TIMER3:   startEvent = timers.timer3Wide ? timers.timer3High : timers.timer3Low;
         default:                startEvent = 1'b0;
      endcase
   end

   // result word
   always_comb
   begin
      if (config_r[sawd_pkg::BIT_JUSTIFY])
         word = {sarCode, 6'b00_0000};
      else if (singleEnded)
         word = {6'b00_0000, sarCode};
      else
         word = {{6{sarCode[DATA_BITS-1]}}, sarCode};
   end

   always_comb
   begin
      if (greaterThan({ltHigh, ltLow}, {gtHigh, gtLow}, !singleEnded))
         winHit = greaterThan(word, {gtHigh, gtLow}, !singleEnded) && greaterThan({ltHigh, ltLow}, word, !singleEnded);
      else
         winHit = greaterThan({ltHigh, ltLow}, word, !singleEnded) || greaterThan(word, {gtHigh, gtLow}, !singleEnded);
   end

   // sequencer and divider
   always_comb
   begin
      next_state      = state;
      next_phaseCount = phaseCount;
      next_divCount   = divCount;
      next_sarTick    = 1'b0;
      next_sarClock   = sarClock;
      finish          = 1'b0;
      if (divCount >= config_r[7:sawd_pkg::BIT_DIV_LSB])
      begin
         next_divCount = 5'd0;
         next_sarTick  = 1'b1;
      end
      else
         next_divCount = divCount + 5'd1;
      if (next_sarTick)
         next_sarClock = 1'b1;
      else if (divCount == {1'b0, config_r[7:4]})
         next_sarClock = 1'b0;
      case (state)
         sawd_pkg::ST_IDLE:
         begin
            if (control[sawd_pkg::BIT_ENABLE] && startEvent)
            begin
               next_phaseCount = 4'd0;
               // restart the divider so every phase spans whole sar periods
               next_divCount   = 5'd1;
               next_sarTick    = config_r[7:sawd_pkg::BIT_DIV_LSB] == 5'd0;
               next_sarClock   = next_sarTick;
               // external waits on rising edge already
               if (control[sawd_pkg::BIT_LPTRACK] && control[2:0] != sawd_pkg::SRC_EXTERNAL)
                  next_state = sawd_pkg::ST_TRACK;
               else
                  next_state = sawd_pkg::ST_CONVERT;
            end
         end
         sawd_pkg::ST_TRACK:
         begin
            if (sarTick)
            begin
               next_phaseCount = phaseCount + 4'd1;
               if (phaseCount == 4'(sawd_pkg::TRACK_SAR_CLOCKS - 1))
               begin
                  next_phaseCount = 4'd0;
                  next_state      = sawd_pkg::ST_CONVERT;
               end
            end
         end
         sawd_pkg::ST_CONVERT:
         begin
            if (sarTick)
            begin
               next_phaseCount = phaseCount + 4'd1;
               if (phaseCount == 4'(sawd_pkg::CONV_SAR_CLOCKS - 1))
               begin
                  finish     = 1'b1;
                  next_state = sawd_pkg::ST_IDLE;
               end
            end
         end
         default: next_state = sawd_pkg::ST_IDLE;
      endcase
      if (!control[sawd_pkg::BIT_ENABLE])
         next_state = sawd_pkg::ST_IDLE;
   end

   // registers, flags and bus
   always_comb
   begin
      next_config  = config_r;
      next_control = control;
      next_modeReg = modeReg;
      next_gtLow   = gtLow;
      next_gtHigh  = gtHigh;
      next_ltLow   = ltLow;
      next_ltHigh  = ltHigh;
      next_result  = result;
      next_irqStat = irqStat;
      next_irqMask = irqMask;
      next_pready  = setup;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (wrEn)
      begin
         case (wIdx)
            sawd_pkg::IDX_CONFIG:   next_config  = {wByte[7:2], 2'b00};
            sawd_pkg::IDX_RES_LOW:  next_result[7:0] = wByte;
            sawd_pkg::IDX_RES_HIGH: next_result[15:8] = wByte;
            // flags clear on zero write only
            sawd_pkg::IDX_CONTROL:
               next_control = {wByte[7:6], control[5] & wByte[5], 1'b0, control[3] & wByte[3], wByte[2:0]};
            sawd_pkg::IDX_MODE:     next_modeReg = {7'd0, wByte[0]};
            sawd_pkg::IDX_GT_LOW:   next_gtLow  = wByte;
            sawd_pkg::IDX_GT_HIGH:  next_gtHigh = wByte;
            sawd_pkg::IDX_LT_LOW:   next_ltLow  = wByte;
            sawd_pkg::IDX_LT_HIGH:  next_ltHigh = wByte;
            sawd_pkg::IDX_IRQ_STAT: next_irqStat = irqStat & ~wByte[1:0];
            sawd_pkg::IDX_IRQ_MASK: next_irqMask = wByte[1:0];
            default:                next_pslverr = 1'b0;
         endcase
      end
      next_control[sawd_pkg::BIT_BUSY] = next_state != sawd_pkg::ST_IDLE;
      if (finish)
      begin
         next_result = word;
         next_control[sawd_pkg::BIT_DONE] = 1'b1;
         next_irqStat[0] = 1'b1;
         if (winHit)
         begin
            next_control[sawd_pkg::BIT_WIN] = 1'b1;
            next_irqStat[1] = 1'b1;
         end
      end
      if (setup && !addrOk)
         next_pslverr = 1'b1;
      else if (setup)
      begin
         case (paddr[9:2])
            sawd_pkg::IDX_CONFIG:   next_prdata[7:0] = config_r;
            sawd_pkg::IDX_RES_LOW:  next_prdata[7:0] = result[7:0];
            sawd_pkg::IDX_RES_HIGH: next_prdata[7:0] = result[15:8];
            sawd_pkg::IDX_CONTROL:  next_prdata[7:0] = control;
            sawd_pkg::IDX_MODE:     next_prdata[7:0] = modeReg;
            sawd_pkg::IDX_GT_LOW:   next_prdata[7:0] = gtLow;
            sawd_pkg::IDX_GT_HIGH:  next_prdata[7:0] = gtHigh;
            sawd_pkg::IDX_LT_LOW:   next_prdata[7:0] = ltLow;
            sawd_pkg::IDX_LT_HIGH:  next_prdata[7:0] = ltHigh;
            sawd_pkg::IDX_IRQ_STAT: next_prdata[1:0] = irqStat;
            sawd_pkg::IDX_IRQ_MASK: next_prdata[1:0] = irqMask;
            default:                next_pslverr = 1'b1;
         endcase
         // a write answers with an empty data word
         if (pwrite)
            next_prdata = 32'h0000_0000;
      end
      next_irq = |(next_irqStat & next_irqMask);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge rstSync)
   begin
      if (!rstSync)
      begin
         config_r      <= sawd_pkg::RST_CONFIG;
         control       <= sawd_pkg::RST_CONTROL;
         modeReg       <= 8'h00_01;
         gtLow         <= sawd_pkg::RST_GT_LOW;
         gtHigh        <= sawd_pkg::RST_GT_HIGH;
         ltLow         <= sawd_pkg::RST_LIMIT;
         ltHigh        <= sawd_pkg::RST_LIMIT;
         result        <= 16'h0000;
         irqStat       <= 2'b00;
         irqMask       <= 2'b00;
         divCount      <= 5'd0;
         sarTick       <= 1'b0;
         phaseCount    <= 4'd0;
         // idle level is high: no false start edge after reset
         extPrev       <= 1'b1;
         state         <= sawd_pkg::ST_IDLE;
         pready        <= 1'b0;
         prdata        <= 32'h0000_0000;
         pslverr       <= 1'b0;
         irq           <= 1'b0;
         sarClock      <= 1'b0;
         trackEnable   <= 1'b0;
         convertActive <= 1'b0;
      end
      else
      begin
         config_r      <= next_config;
         control       <= next_control;
         modeReg       <= next_modeReg;
         gtLow         <= next_gtLow;
         gtHigh        <= next_gtHigh;
         ltLow         <= next_ltLow;
         ltHigh        <= next_ltHigh;
         result        <= next_result;
         irqStat       <= next_irqStat;
         irqMask       <= next_irqMask;
         divCount      <= next_divCount;
         sarTick       <= next_sarTick;
         phaseCount    <= next_phaseCount;
         extPrev       <= externalStartInput;
         state         <= next_state;
         pready        <= next_pready;
         prdata        <= next_prdata;
         pslverr       <= next_pslverr;
         irq           <= next_irq;
         sarClock      <= next_sarClock;
         if (next_control[sawd_pkg::BIT_LPTRACK] && next_control[2:0] == sawd_pkg::SRC_EXTERNAL)
            trackEnable <= next_control[sawd_pkg::BIT_ENABLE] && !externalStartInput
                           && next_state == sawd_pkg::ST_IDLE;
         else if (next_control[sawd_pkg::BIT_LPTRACK])
            trackEnable <= next_state == sawd_pkg::ST_TRACK;
         else
            trackEnable <= next_control[sawd_pkg::BIT_ENABLE] && next_state == sawd_pkg::ST_IDLE;
         convertActive <= next_state == sawd_pkg::ST_CONVERT;
      end
   end

endmodule

// ### sawd_pkg.sv
package sawd_pkg;

   // register offsets: printed offsets are not all multiples of four, so they are indices
   localparam logic [7:0] IDX_CONFIG   = 8'h00_bc;
   localparam logic [7:0] IDX_RES_LOW  = 8'h00_bd;
   localparam logic [7:0] IDX_CONTROL  = 8'h00_e8;
   // registers without a printed offset
   localparam logic [7:0] IDX_RES_HIGH = 8'h00_be;
   localparam logic [7:0] IDX_GT_LOW   = 8'h00_c3;
   localparam logic [7:0] IDX_GT_HIGH  = 8'h00_c4;
   localparam logic [7:0] IDX_LT_LOW   = 8'h00_c5;
   localparam logic [7:0] IDX_LT_HIGH  = 8'h00_c6;
   localparam logic [7:0] IDX_MODE     = 8'h00_ba;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h00_c8;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h00_c9;

   localparam logic [7:0] RST_CONFIG   = 8'h00_f8;
   localparam logic [7:0] RST_CONTROL  = 8'h00_00;
   localparam logic [7:0] RST_LIMIT    = 8'h00_00;
   localparam logic [7:0] RST_GT_HIGH  = 8'h00_ff;
   localparam logic [7:0] RST_GT_LOW   = 8'h00_ff;

   // control register bit positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_LPTRACK = 6;
   localparam int BIT_DONE = 5;
   localparam int BIT_BUSY = 4;
   localparam int BIT_WIN = 3;
   // config register: divider in bits 7..3, justify in bit 2
   localparam int BIT_DIV_LSB = 3;
   localparam int BIT_JUSTIFY = 2;
   // mode register bit 0: negative input is ground
   localparam int BIT_NEG_GND = 0;

   localparam int TRACK_SAR_CLOCKS = 3;
   localparam int CONV_SAR_CLOCKS  = 10;

   typedef enum logic [2:0]
   {
      SRC_SOFTWARE = 3'b000,
      SRC_TIMER0   = 3'b001,
      SRC_TIMER2   = 3'b010,
      SRC_TIMER1   = 3'b011,
      SRC_EXTERNAL = 3'b100,
      SRC_TIMER3   = 3'b101
   } sawd_source_t;

   typedef enum logic [1:0]
   {
      ST_IDLE    = 2'b00,
      ST_TRACK   = 2'b01,
      ST_CONVERT = 2'b10
   } sawd_state_t;

   typedef struct packed
   {
      logic timer0;
      logic timer1;
      logic timer2Low;
      logic timer2High;
      logic timer2Wide;
      logic timer3Low;
      logic timer3High;
      logic timer3Wide;
   } sawd_timers_t;

endpackage

// ### sawd_sar_model.sv
`timescale 1ns/1ps
module sawd_sar_model
(
   input  wire logic       clk_sys,
   input  wire logic       convertActive,
   input  wire logic [9:0] codeIn,
   output logic      [9:0] sarCode
);
   logic [9:0] drift = 10'h155;
   logic       late  = 1'b0;
   ////////////////////////////////////////////////////////////
   // code held through conversion
   // one spare cycle allows a sample on the closing edge; later the lines wander
   always_ff @(posedge clk_sys)
   begin
      drift <= drift + 10'h0f3;
      late  <= convertActive;
   end
   assign sarCode = (convertActive || late) ? codeIn : drift;
endmodule

// ### sawd_adc_control_sva.sv
`timescale 1ns/1ps
module sawd_adc_control_sva
(
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        sarClock,
   input wire logic        trackEnable,
   input wire logic        convertActive,
   input wire logic        irq
);
   logic       prevSar;
   logic [7:0] ticks;
   logic [7:0] next_ticks;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   function automatic logic mapped(input logic [11:0] a);
      return a[1:0] == 2'h0 && a[11:10] == 2'h0 && a[9:2] inside {sawd_pkg::IDX_CONFIG,
         sawd_pkg::IDX_RES_LOW, sawd_pkg::IDX_RES_HIGH, sawd_pkg::IDX_CONTROL, sawd_pkg::IDX_MODE,
         sawd_pkg::IDX_GT_LOW, sawd_pkg::IDX_GT_HIGH, sawd_pkg::IDX_LT_LOW, sawd_pkg::IDX_LT_HIGH,
         sawd_pkg::IDX_IRQ_STAT, sawd_pkg::IDX_IRQ_MASK};
   endfunction
   ////////////////////////////////////////////////////////////
   // sar rising edges seen inside one conversion
   always_comb
   begin
      next_ticks = convertActive ? ticks : 8'h00;
      if (convertActive && sarClock && !prevSar)
         next_ticks = ticks + 8'h01;
   end
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prevSar <= 1'b0;
         ticks   <= 8'h00;
      end
      else
      begin
         prevSar <= sarClock;
         ticks   <= next_ticks;
      end
   end
   ////////////////////////////////////////////////////////////
   pready_answer_a : assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   pready_pulse_a : assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   pready_access_a : assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   slverr_map_a : assert property (pready |-> pslverr == !mapped(paddr))
      else $error("slave error wrong for address");
   slverr_zero_a : assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read not zero");
   prdata_pad_a : assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   // a divider field of zero holds the sar clock high; this check needs a field above zero
   conv_len_a : assert property ($fell(convertActive) |-> ticks >= 8'h0a)
      else $error("conversion too short");
   track_conv_a : assert property (trackEnable |-> !convertActive)
      else $error("tracking during conversion");
   cover property ($fell(convertActive));
   cover property ($fell(trackEnable) ##1 convertActive);
   cover property (pready && pslverr);
   cover property ($rose(irq));
endmodule

bind sawd_adc_control sawd_adc_control_sva i_sawd_adc_control_sva
   (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
    .sarClock, .trackEnable, .convertActive, .irq);

// ### sawd_adc_control_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module sawd_adc_control_tb;
   typedef struct packed {logic neg; logic [15:0] gt; logic [15:0] lt; logic [9:0] code; logic win;} sawd_win_t;
   typedef struct packed {logic [7:0] ctrl; logic [7:0] vec; logic go;} sawd_src_t;
   localparam sawd_win_t WROWS[9] = '{'{1'h1, 16'h0040, 16'h0080, 10'h041, 1'h1},
      '{1'h1, 16'h0040, 16'h0080, 10'h040, 1'h0}, '{1'h1, 16'h0040, 16'h0080, 10'h080, 1'h0},
      '{1'h1, 16'h0080, 16'h0040, 10'h03f, 1'h1}, '{1'h1, 16'h0080, 16'h0040, 10'h060, 1'h0},
      '{1'h1, 16'h0080, 16'h0040, 10'h081, 1'h1}, '{1'h0, 16'hffff, 16'h0040, 10'h000, 1'h1},
      '{1'h0, 16'hffff, 16'h0040, 10'h3ff, 1'h0}, '{1'h0, 16'h0040, 16'hffff, 10'h3fe, 1'h1}};
   localparam sawd_src_t SROWS[10] = '{'{8'h81, 8'h80, 1'h1}, '{8'h82, 8'h20, 1'h1},
      '{8'h82, 8'h10, 1'h0}, '{8'h82, 8'h18, 1'h1}, '{8'h82, 8'h28, 1'h0}, '{8'h83, 8'h40, 1'h1},
      '{8'h85, 8'h04, 1'h1}, '{8'h85, 8'h03, 1'h1}, '{8'h86, 8'hff, 1'h0}, '{8'h10, 8'h00, 1'h0}};
   localparam logic [15:0] RST[8] = '{{sawd_pkg::IDX_CONFIG, sawd_pkg::RST_CONFIG},
      {sawd_pkg::IDX_CONTROL, sawd_pkg::RST_CONTROL}, {sawd_pkg::IDX_GT_LOW, sawd_pkg::RST_GT_LOW},
      {sawd_pkg::IDX_GT_HIGH, sawd_pkg::RST_GT_HIGH}, {sawd_pkg::IDX_LT_LOW, sawd_pkg::RST_LIMIT},
      {sawd_pkg::IDX_LT_HIGH, sawd_pkg::RST_LIMIT}, {sawd_pkg::IDX_IRQ_MASK, 8'h00},
      {sawd_pkg::IDX_MODE, 8'h01}};
   logic        clk_sys  = 1'h0;
   logic        resetn   = 1'h0;
   logic        psel     = 1'h0;
   logic        penable  = 1'h0;
   logic        pwrite   = 1'h0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic        extStart = 1'h1;
   logic [9:0]  code     = 10'h000;
   logic [7:0]  tmrBits  = 8'h00;
   logic        pready, pslverr, sarClock, trackEnable, convertActive, irq, err, rdy, prev;
   logic [31:0] prdata;
   logic [9:0]  sarCode;
   logic [7:0]  rd;
   logic [15:0] res;
   int          error_cnt    = 0;
   int          total_checks = 0;
   int          n, k, t0, t1;

   initial
      forever #12.5 clk_sys = ~clk_sys;

   sawd_adc_control i_sawd_adc_control
   (
      .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .timers(sawd_pkg::sawd_timers_t'(tmrBits)), .externalStartInput(extStart), .sarCode,
      .sarClock, .trackEnable, .convertActive, .irq
   );
   sawd_sar_model i_sawd_sar_model (.clk_sys, .convertActive, .codeIn(code), .sarCode);
   ////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // request held until pready is sampled, one idle edge after release
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int c;
      c = 0;
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= {2'h0, idx, 2'h0};
      pwdata <= {24'h00_0000, d};
      @(posedge clk_sys);
      penable <= 1'h1;
      do
      begin
         @(posedge clk_sys);
         c++;
      end
      while (pready !== 1'h1 && c < 20);
      rdy = pready;
      rd  = prdata[7:0];
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys);
      if (rdy !== 1'h1)
      begin
         error_cnt++;
         conclude();
      end
   endtask

   task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
      bus(1'h0, idx, 8'h00);
      `CHK(nm, e, rd)
   endtask

   task automatic waitDone;
      int c;
      c = 0;
      do
      begin
         bus(1'h0, sawd_pkg::IDX_CONTROL, 8'h00);
         c++;
      end
      while (rd[5] !== 1'h1 && c < 80);
      if (rd[5] !== 1'h1)
      begin
         error_cnt++;
         conclude();
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'h1;
      repeat (3) @(posedge clk_sys);
      foreach (RST[i])
         rchk("reset", RST[i][15:8], RST[i][7:0]);
      bus(1'h0, 8'h01, 8'h00);
      `CHK("unmapped", 1'h1, err)
      bus(1'h1, sawd_pkg::IDX_CONFIG, 8'h18);
      rchk("config", sawd_pkg::IDX_CONFIG, 8'h18);
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'h80);
      foreach (WROWS[i])
      begin
         bus(1'h1, sawd_pkg::IDX_MODE, {7'h00, WROWS[i].neg});
         bus(1'h1, sawd_pkg::IDX_GT_LOW, WROWS[i].gt[7:0]);
         bus(1'h1, sawd_pkg::IDX_GT_HIGH, WROWS[i].gt[15:8]);
         bus(1'h1, sawd_pkg::IDX_LT_LOW, WROWS[i].lt[7:0]);
         bus(1'h1, sawd_pkg::IDX_LT_HIGH, WROWS[i].lt[15:8]);
         code <= WROWS[i].code;
         bus(1'h1, sawd_pkg::IDX_CONTROL, 8'h90);
         waitDone();
         `CHK("window", WROWS[i].win, rd[3])
         res = WROWS[i].neg ? {6'h00, WROWS[i].code} : {{6{WROWS[i].code[9]}}, WROWS[i].code};
         rchk("resHigh", sawd_pkg::IDX_RES_HIGH, res[15:8]);
         rchk("resLow", sawd_pkg::IDX_RES_LOW, res[7:0]);
      end
      foreach (SROWS[i])
      begin
         tmrBits <= SROWS[i].vec & 8'h09;
         bus(1'h1, sawd_pkg::IDX_CONTROL, SROWS[i].ctrl);
         tmrBits <= SROWS[i].vec;
         @(posedge clk_sys);
         tmrBits <= SROWS[i].vec & 8'h09;
         repeat (80) @(posedge clk_sys);
         bus(1'h0, sawd_pkg::IDX_CONTROL, 8'h00);
         `CHK("started", SROWS[i].go, rd[5])
      end
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'hc0);
      n = 0;
      k = 0;
      t0 = 0;
      t1 = 0;
      fork
         bus(1'h1, sawd_pkg::IDX_CONTROL, 8'hd0);
         begin
            while (trackEnable !== 1'h1 && n < 60)
            begin
               @(posedge clk_sys);
               n++;
            end
            while (trackEnable === 1'h1 && n < 200)
            begin
               @(posedge clk_sys);
               n++;
               k++;
            end
            prev = sarClock;
            while (t1 == 0 && n < 300)
            begin
               @(posedge clk_sys);
               n++;
               if (sarClock === 1'h1 && prev === 1'h0)
               begin
                  t1 = t0;
                  t0 = n;
               end
               prev = sarClock;
            end
         end
      join
      if (k == 0 || t1 == 0)
      begin
         error_cnt++;
         conclude();
      end
      `CHK("trackLen", 3 * 4, k)
      `CHK("sarPeriod", 4, t0 - t1)
      waitDone();
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'hc4);
      extStart <= 1'h0;
      repeat (10) @(posedge clk_sys);
      `CHK("extTrack", 1'h1, trackEnable)
      `CHK("extHold", 1'h0, convertActive)
      extStart <= 1'h1;
      waitDone();
      bus(1'h1, sawd_pkg::IDX_CONFIG, 8'h1c);
      bus(1'h1, sawd_pkg::IDX_MODE, 8'h01);
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'h80);
      code <= 10'h2a5;
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'h90);
      waitDone();
      rchk("leftHigh", sawd_pkg::IDX_RES_HIGH, 8'ha9);
      rchk("leftLow", sawd_pkg::IDX_RES_LOW, 8'h40);
      repeat (20) @(posedge clk_sys);
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'ha0);
      bus(1'h0, sawd_pkg::IDX_CONTROL, 8'h00);
      `CHK("doneKept", 1'h1, rd[5])
      `CHK("irqMasked", 1'h0, irq)
      bus(1'h1, sawd_pkg::IDX_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk_sys);
      `CHK("irqRaised", 1'h1, irq)
      bus(1'h1, sawd_pkg::IDX_CONTROL, 8'h80);
      bus(1'h0, sawd_pkg::IDX_CONTROL, 8'h00);
      `CHK("doneCleared", 1'h0, rd[5])
      bus(1'h1, sawd_pkg::IDX_IRQ_STAT, 8'h03);
      repeat (2) @(posedge clk_sys);
      `CHK("irqCleared", 1'h0, irq)
      rchk("status", sawd_pkg::IDX_IRQ_STAT, 8'h00);
      conclude();
   end
endmodule
